// ==== lin_field_model.sv ====
// Model of the control switches and breaker auxiliary contacts
`timescale 1ns/100ps
module lin_field_model (
  input wire logic core_clk,
  input wire logic [7:0] sw_cmd,
  input wire logic [1:0] brk_state,
  output logic [7:0] logic_in = 8'h00,
  output logic breaker_aux_contact_a = 1'b1,
  output logic breaker_aux_contact_b = 1'b0
);
  // Contacts move on the clock; state 0 closed, 1 open, 2 both low, 3 both high
  // Both indeterminate flavours exist because a stuck contact may read either way
  always @(posedge core_clk)
  begin
    logic_in <= sw_cmd;
    breaker_aux_contact_a <= (brk_state == 2'h0) || (brk_state == 2'h3);
    breaker_aux_contact_b <= (brk_state == 2'h1) || (brk_state == 2'h3);
  end
endmodule

// ==== lin_pkg.sv ====
// Package with constants shared by the logical input block
package lin_pkg;

  // ***************************************************************
  // Register map (byte addresses, AXI4-Lite, one word each)
  // ***************************************************************
  localparam logic [7:0] off_assign = 8'h00;
  localparam logic [7:0] off_ctrl = 8'h04;
  localparam logic [7:0] off_status = 8'h08;
  localparam logic [7:0] off_int_status = 8'h0c;
  localparam logic [7:0] off_int_mask = 8'h10;
  localparam logic [7:0] off_capture_len = 8'h14;

  // ***************************************************************
  // Logical input indices within the assignment and level vectors
  // ***************************************************************
  localparam int num_inputs = 8;
  localparam int in_reclose_multi = 0;
  localparam int in_open = 1;
  localparam int in_close = 2;
  localparam int in_event_a = 3;
  localparam int in_event_b = 4;
  localparam int in_wave = 5;
  localparam int in_neg_seq_trip = 6;
  localparam int in_neg_seq_alarm = 7;

  // Level each input reads when not assigned
  localparam logic [7:0] unassigned_default = 8'hc0;

  // ***************************************************************
  // Status and interrupt bit positions
  // ***************************************************************
  localparam int st_close_pending = 0;
  localparam int st_breaker_open = 1;
  localparam int st_indeterminate = 2;
  localparam int ev_event_a = 0;
  localparam int ev_event_b = 1;
  localparam int ev_wave = 2;
  localparam int ev_close_drop = 3;
  localparam int num_events = 4;

  // Control register bit: manual drive trip mode
  localparam int ctrl_manual_drive = 0;

  // Default waveform capture length in power cycles
  localparam logic [7:0] capture_len_reset = 8'h10;

  // AXI responses
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

endpackage

// ==== lin_sync.sv ====
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module lin_sync #(
  parameter int width = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_sync
);

  logic [width-1:0] meta_q;
  logic [width-1:0] sync_q;

  // Only the second stage is ever read downstream
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_sync = sync_q;

endmodule

// ==== relay_logical_input_actions.sv ====
// Logical input interpretation for a protection relay, with AXI4-Lite registers
// Functional notes
// RULE_01 - Multi-shot reclose input high enables multi-shot reclosing after external breaker open.
// RULE_02 - Unassigned multi-shot reclose input reads low, disabled.
// RULE_03 - Open command high drives the master trip output.
// RULE_04 - Unassigned open command reads low.
// RULE_05 - Close command high asserts the close logical output.
// RULE_06 - Unassigned close command reads low.
// RULE_07 - Close while auxiliary contacts agree is held pending.
// RULE_08 - Pending close executes once contacts become determinate and show breaker open.
// RULE_09 - Pending close is dropped on unit reset or power cycle.
// RULE_10 - First event input high logs its event once; unassigned reads low.
// RULE_11 - Second event input high logs its event once; unassigned reads low.
// RULE_12 - Waveform input high starts a capture of the configured cycle count.
// RULE_13 - Unassigned waveform input reads low, no capture.
// RULE_14 - Negative-sequence trip element enabled only while its enable is high.
// RULE_15 - Unassigned negative-sequence trip enable reads high.
// RULE_16 - Negative-sequence alarm element enabled only while its enable is high.
// RULE_17 - Unassigned negative-sequence alarm enable reads high.
// RULE_18 - Inputs evaluated each scan; commands level, event requests once per rise.
`timescale 1ns/100ps
module relay_logical_input_actions (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic scan_tick,
  input wire logic [7:0] logic_in,
  input wire logic breaker_aux_contact_a,
  input wire logic breaker_aux_contact_b,
  input wire logic external_open_seen,
  output logic master_trip,
  output logic close_out,
  output logic multi_shot_reclose_active,
  output logic neg_seq_trip_enable,
  output logic neg_seq_alarm_enable,
  output logic event_log_a,
  output logic event_log_b,
  output logic wave_capture_start,
  output logic [7:0] wave_capture_cycles,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [9:0] raw_pins;
  logic [9:0] sync_pins;
  logic [7:0] pin_lvl;
  logic aux_a;
  logic aux_b;

  assign raw_pins = {breaker_aux_contact_b, breaker_aux_contact_a, logic_in};

  lin_sync #(.width(10)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(raw_pins),
    .pin_sync(sync_pins)
  );

  assign pin_lvl = sync_pins[7:0];
  assign aux_a = sync_pins[8];
  assign aux_b = sync_pins[9];

  // ***************************************************************
  // Register state
  // ***************************************************************
  logic [7:0] assign_q, assign_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [3:0] int_status_q, int_status_d;
  logic [3:0] int_mask_q, int_mask_d;
  logic [7:0] capture_len_q, capture_len_d;

  // ***************************************************************
  // Effective logical levels
  // ***************************************************************
  logic [7:0] eff_lvl;

  // Unassigned inputs read their fixed default
  always_comb
  begin
    eff_lvl = (pin_lvl & assign_q) | (lin_pkg::unassigned_default & ~assign_q); // RULE_02 RULE_04 RULE_06 RULE_13 RULE_15 RULE_17
  end

  // ***************************************************************
  // Scan-sampled inputs, pending close and event edges
  // ***************************************************************
  logic [7:0] lvl_q, lvl_d;
  logic pend_q, pend_d;
  logic close_q, close_d;
  logic [2:0] ev_pulse_q, ev_pulse_d;
  logic indeterminate;
  logic brk_open;
  logic close_now;
  logic [2:0] rise;
  logic [3:0] ev_set;

  assign indeterminate = (aux_a == aux_b);
  assign brk_open = ~aux_a & aux_b;
  assign close_now = lvl_q[lin_pkg::in_close];
  assign rise = {eff_lvl[lin_pkg::in_wave] & ~lvl_q[lin_pkg::in_wave],
    eff_lvl[lin_pkg::in_event_b] & ~lvl_q[lin_pkg::in_event_b],
    eff_lvl[lin_pkg::in_event_a] & ~lvl_q[lin_pkg::in_event_a]};

  // Inputs refresh only on a protection scan tick
  always_comb
  begin
    lvl_d = scan_tick ? eff_lvl : lvl_q; // RULE_18
    ev_pulse_d = scan_tick ? rise : 3'h0; // RULE_10 RULE_11 RULE_18
    pend_d = pend_q;
    close_d = 1'b0;
    if (close_now && indeterminate)
    begin
      pend_d = 1'b1; // RULE_07
    end
    else if (pend_q && !indeterminate)
    begin
      // Determinate again: run only if breaker shows open, else forget
      close_d = brk_open; // RULE_08
      pend_d = 1'b0;
    end
    else if (close_now)
    begin
      close_d = 1'b1; // RULE_05
    end
    ev_set = {pend_q & ~pend_d & ~brk_open, ev_pulse_q};
  end

  // Reset clears the pending close, as does a power cycle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      lvl_q <= lin_pkg::unassigned_default;
      pend_q <= 1'b0; // RULE_09
      close_q <= 1'b0;
      ev_pulse_q <= 3'h0;
    end
    else
    begin
      lvl_q <= lvl_d;
      pend_q <= pend_d;
      close_q <= close_d;
      ev_pulse_q <= ev_pulse_d;
    end
  end

  // Output actions
  assign master_trip = lvl_q[lin_pkg::in_open]; // RULE_03
  assign close_out = close_q;
  assign multi_shot_reclose_active = lvl_q[lin_pkg::in_reclose_multi] & external_open_seen; // RULE_01
  assign neg_seq_trip_enable = lvl_q[lin_pkg::in_neg_seq_trip]; // RULE_14
  assign neg_seq_alarm_enable = lvl_q[lin_pkg::in_neg_seq_alarm]; // RULE_16
  assign event_log_a = ev_pulse_q[lin_pkg::ev_event_a]; // RULE_10
  assign event_log_b = ev_pulse_q[lin_pkg::ev_event_b]; // RULE_11
  assign wave_capture_start = ev_pulse_q[lin_pkg::ev_wave]; // RULE_12
  assign wave_capture_cycles = capture_len_q; // RULE_12
  assign irq = |(int_status_q & int_mask_q);

  // ***************************************************************
  // AXI4-Lite slave
  // ***************************************************************
  logic aw_have_q, aw_have_d;
  logic w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic do_write;
  logic [3:0] w1c;

  assign s_axi_awready = ~aw_have_q & ~bvalid_q;
  assign s_axi_wready = ~w_have_q & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Capture address and data in either order, answer once both are held
  always_comb
  begin
    aw_have_d = aw_have_q | (s_axi_awvalid & s_axi_awready);
    w_have_d = w_have_q | (s_axi_wvalid & s_axi_wready);
    awaddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
    do_write = aw_have_q & w_have_q & ~bvalid_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (bvalid_q && s_axi_bready)
    begin
      bvalid_d = 1'b0;
    end
    if (do_write)
    begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = lin_pkg::resp_okay;
      case (awaddr_q)
        lin_pkg::off_assign, lin_pkg::off_ctrl, lin_pkg::off_int_status,
        lin_pkg::off_int_mask, lin_pkg::off_capture_len: bresp_d = lin_pkg::resp_okay;
        default: bresp_d = lin_pkg::resp_slverr;
      endcase
    end
  end

  // Register writes; hardware set beats software clear
  always_comb
  begin
    assign_d = assign_q;
    ctrl_d = ctrl_q;
    int_mask_d = int_mask_q;
    capture_len_d = capture_len_q;
    w1c = 4'h0;
    if (do_write && s_axi_wstrb[0])
    begin
      case (awaddr_q)
        lin_pkg::off_assign: assign_d = wdata_q[7:0];
        lin_pkg::off_ctrl: ctrl_d = {31'h0, wdata_q[lin_pkg::ctrl_manual_drive]};
        lin_pkg::off_int_status: w1c = wdata_q[3:0];
        lin_pkg::off_int_mask: int_mask_d = wdata_q[3:0];
        lin_pkg::off_capture_len: capture_len_d = wdata_q[7:0];
        default: w1c = 4'h0;
      endcase
    end
    int_status_d = (int_status_q & ~w1c) | ev_set;
  end

  // Read path: mapped registers answer OKAY, others SLVERR with zero data
  always_comb
  begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rvalid_q && s_axi_rready)
    begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_d = 1'b1;
      rresp_d = lin_pkg::resp_okay;
      case (s_axi_araddr)
        lin_pkg::off_assign: rdata_d = {24'h0, assign_q};
        lin_pkg::off_ctrl: rdata_d = ctrl_q;
        lin_pkg::off_status: rdata_d = {21'h0, lvl_q, indeterminate, brk_open, pend_q};
        lin_pkg::off_int_status: rdata_d = {28'h0, int_status_q};
        lin_pkg::off_int_mask: rdata_d = {28'h0, int_mask_q};
        lin_pkg::off_capture_len: rdata_d = {24'h0, capture_len_q};
        default:
        begin
          rdata_d = 32'h0;
          rresp_d = lin_pkg::resp_slverr;
        end
      endcase
    end
  end

  // Registers of the bus slave and the software-visible state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h0;
      wdata_q <= 32'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
      assign_q <= 8'h0;
      ctrl_q <= 32'h0;
      int_status_q <= 4'h0;
      int_mask_q <= 4'h0;
      capture_len_q <= lin_pkg::capture_len_reset;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      assign_q <= assign_d;
      ctrl_q <= ctrl_d;
      int_status_q <= int_status_d;
      int_mask_q <= int_mask_d;
      capture_len_q <= capture_len_d;
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_trip_follows_open: assert property (scan_tick && eff_lvl[lin_pkg::in_open] |=> master_trip) // RULE_03
    else $error("Trip does not follow open input");
  chk_unassigned_defaults: assert property (scan_tick |=> ((lvl_q & ~$past(assign_q)) == (lin_pkg::unassigned_default & ~$past(assign_q)))) // RULE_02
    else $error("Unassigned input not at default");
  chk_pending_set: assert property (close_now && indeterminate |=> pend_q && !close_out) // RULE_07
    else $error("Indeterminate close not held");
  chk_pending_exec: assert property (pend_q && !indeterminate && brk_open && !close_now |=> close_out && !pend_q) // RULE_08
    else $error("Pending close not executed");
  chk_close_direct: assert property (close_now && !indeterminate && !pend_q |=> close_out) // RULE_05
    else $error("Close output missing");
  chk_event_one_pulse: assert property (event_log_a |=> !event_log_a) // RULE_10
    else $error("Event a logged twice");
  chk_event_b_rise: assert property (scan_tick && eff_lvl[lin_pkg::in_event_b] && !lvl_q[lin_pkg::in_event_b] |=> event_log_b) // RULE_11
    else $error("Event b not logged");
  chk_wave_start: assert property (scan_tick && eff_lvl[lin_pkg::in_wave] && !lvl_q[lin_pkg::in_wave] |=> wave_capture_start) // RULE_12
    else $error("Capture not started");
  chk_scan_hold: assert property (!scan_tick |=> $stable(lvl_q)) // RULE_18
    else $error("Input level moved off scan");
  chk_neg_seq_enables: assert property (scan_tick && !eff_lvl[lin_pkg::in_neg_seq_trip] && !eff_lvl[lin_pkg::in_neg_seq_alarm] |=> !neg_seq_trip_enable && !neg_seq_alarm_enable) // RULE_14 RULE_16
    else $error("Neg seq enable mismatch");
  chk_reclose_gate: assert property (scan_tick && !eff_lvl[lin_pkg::in_reclose_multi] |=> !multi_shot_reclose_active) // RULE_01
    else $error("Reclose without enable");

  cov_pending_close: cover property (pend_q ##[1:20] close_out);
  cov_event_a: cover property (event_log_a);
  cov_wave: cover property (wave_capture_start);
  cov_irq: cover property (irq);

endmodule

// ==== testbench.sv ====
// Self-checking bench for the logical input block
`timescale 1ns/100ps
`define CHECK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scan_tick = 1'b0;
  logic [7:0] sw_cmd = 8'h00;
  logic [1:0] brk_state = 2'h1;
  logic external_open_seen = 1'b0;
  logic [7:0] logic_in;
  logic aux_a, aux_b, master_trip, close_out, reclose_on, nst_en, nsa_en;
  logic ev_a, ev_b, wave_go, irq;
  logic [7:0] wave_cycles;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] rd;
  int num_errors = 0, num_checks = 0, n_ev_a = 0, n_ev_b = 0, n_wave = 0, n_close = 0;
  int scan_cnt = 0, base;
  // ***************************************************************
  // Clock, scan strobe and pulse counters
  // ***************************************************************
  always #5 core_clk = ~core_clk;
  // Scan every fourth cycle, so a pin change shows at the first scan after the synchroniser
  always @(posedge core_clk)
  begin
    scan_cnt <= (scan_cnt + 1) % 4;
    scan_tick <= (scan_cnt == 3);
    n_ev_a <= n_ev_a + int'(ev_a === 1'b1);
    n_ev_b <= n_ev_b + int'(ev_b === 1'b1);
    n_wave <= n_wave + int'(wave_go === 1'b1);
    n_close <= n_close + int'(close_out === 1'b1);
  end
  lin_field_model field_u (.core_clk(core_clk), .sw_cmd(sw_cmd), .brk_state(brk_state),
    .logic_in(logic_in), .breaker_aux_contact_a(aux_a), .breaker_aux_contact_b(aux_b));
  relay_logical_input_actions dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .scan_tick(scan_tick), .logic_in(logic_in), .breaker_aux_contact_a(aux_a),
    .breaker_aux_contact_b(aux_b), .external_open_seen(external_open_seen),
    .master_trip(master_trip), .close_out(close_out), .multi_shot_reclose_active(reclose_on),
    .neg_seq_trip_enable(nst_en), .neg_seq_alarm_enable(nsa_en), .event_log_a(ev_a),
    .event_log_b(ev_b), .wave_capture_start(wave_go), .wave_capture_cycles(wave_cycles),
    .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  // ***************************************************************
  // Bus tasks
  // ***************************************************************
  // Write one word; each channel is released at the edge that takes it
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done && n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        done = 1'b1;
        s_axi_bready <= 1'b0;
        `CHECK("bresp", er, s_axi_bresp)
      end
    end
    if (!done) `CHECK("write answer", 1'b1, done)
  endtask
  // Read one word into rd and compare its response code
  task automatic axi_read(input logic [7:0] a, input logic [1:0] er);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done && n < 50)
    begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        done = 1'b1;
        rd = s_axi_rdata;
        s_axi_rready <= 1'b0;
        `CHECK("rresp", er, s_axi_rresp)
      end
    end
    if (!done) `CHECK("read answer", 1'b1, done)
  endtask
  // Let a pin change pass the synchroniser and at least two scans
  task automatic settle;
    repeat (14) @(posedge core_clk);
  endtask
  task automatic pins(input logic [7:0] v, input logic [1:0] b);
    @(posedge core_clk);
    sw_cmd <= v;
    brk_state <= b;
    settle();
  endtask
  task automatic pulse_reset;
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    $display("BAD watchdog expired");
    print_verdict();
  end
  // ***************************************************************
  // Tests
  // ***************************************************************
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    axi_read(lin_pkg::off_capture_len, lin_pkg::resp_okay);
    `CHECK("capture len reset", 32'h10, rd)
    axi_read(8'h18, lin_pkg::resp_slverr);
    `CHECK("unmapped data", 32'h0, rd)
    axi_write(8'h18, 32'h1, lin_pkg::resp_slverr);
    // Only the manual drive bit of the control word is kept
    axi_write(lin_pkg::off_ctrl, 32'hffffffff, lin_pkg::resp_okay);
    axi_read(lin_pkg::off_ctrl, lin_pkg::resp_okay);
    `CHECK("ctrl mode bit", 32'h1, rd)
    // Unassigned inputs read their defaults whatever the pins do
    pins(8'hff, 2'h1);
    `CHECK("unassigned trip", 1'b0, master_trip)
    `CHECK("unassigned close", 1'b0, close_out)
    external_open_seen <= 1'b1;
    settle();
    `CHECK("unassigned reclose", 1'b0, reclose_on)
    `CHECK("unassigned events", 0, n_ev_a + n_ev_b)
    `CHECK("unassigned wave", 0, n_wave)
    pins(8'h00, 2'h1);
    `CHECK("unassigned nst", 1'b1, nst_en)
    `CHECK("unassigned nsa", 1'b1, nsa_en)
    $display("test defaults done");
    // Assigned levels follow the pins
    axi_write(lin_pkg::off_assign, 32'hff, lin_pkg::resp_okay);
    settle();
    `CHECK("nst off", 1'b0, nst_en)
    `CHECK("nsa off", 1'b0, nsa_en)
    pins(8'hc3, 2'h1);
    `CHECK("trip", 1'b1, master_trip)
    `CHECK("reclose", 1'b1, reclose_on)
    `CHECK("nst on", 1'b1, nst_en)
    `CHECK("nsa on", 1'b1, nsa_en)
    external_open_seen <= 1'b0;
    settle();
    `CHECK("reclose no ext", 1'b0, reclose_on)
    pins(8'h04, 2'h1);
    `CHECK("close", 1'b1, close_out)
    `CHECK("trip off", 1'b0, master_trip)
    pins(8'h00, 2'h1);
    $display("test levels done");
    // Events: one pulse per rise even while held high
    axi_write(lin_pkg::off_capture_len, 32'h2a, lin_pkg::resp_okay);
    base = n_ev_a;
    pins(8'h08, 2'h1);
    settle();
    `CHECK("event a once", base + 1, n_ev_a)
    base = n_ev_b;
    pins(8'h10, 2'h1);
    `CHECK("event b once", base + 1, n_ev_b)
    base = n_wave;
    pins(8'h20, 2'h1);
    `CHECK("wave once", base + 1, n_wave)
    `CHECK("wave cycles", 8'h2a, wave_cycles)
    pins(8'h00, 2'h1);
    axi_read(lin_pkg::off_int_status, lin_pkg::resp_okay);
    `CHECK("int status", 3'h7, rd[2:0])
    `CHECK("irq masked", 1'b0, irq)
    axi_write(lin_pkg::off_int_mask, 32'h1, lin_pkg::resp_okay);
    `CHECK("irq on", 1'b1, irq)
    axi_write(lin_pkg::off_int_status, 32'h7, lin_pkg::resp_okay);
    `CHECK("irq cleared", 1'b0, irq)
    $display("test events done");
    // Close held while contacts agree, then done when breaker shows open
    pins(8'h04, 2'h2);
    `CHECK("held close", 1'b0, close_out)
    axi_read(lin_pkg::off_status, lin_pkg::resp_okay);
    `CHECK("pending", 1'b1, rd[lin_pkg::st_close_pending])
    pins(8'h00, 2'h3);
    base = n_close;
    pins(8'h00, 2'h1);
    `CHECK("pending done", base + 1, n_close)
    axi_read(lin_pkg::off_status, lin_pkg::resp_okay);
    `CHECK("pending gone", 1'b0, rd[lin_pkg::st_close_pending])
    // Pending close dropped when breaker shows closed
    pins(8'h04, 2'h3);
    pins(8'h00, 2'h3);
    base = n_close;
    pins(8'h00, 2'h0);
    `CHECK("no close on closed", base, n_close)
    axi_write(lin_pkg::off_int_mask, 32'h8, lin_pkg::resp_okay);
    `CHECK("drop irq", 1'b1, irq)
    axi_write(lin_pkg::off_int_status, 32'h8, lin_pkg::resp_okay);
    `CHECK("drop irq clear", 1'b0, irq)
    // Pending close lost over a reset
    pins(8'h04, 2'h2);
    pins(8'h00, 2'h2);
    pulse_reset();
    axi_write(lin_pkg::off_assign, 32'hff, lin_pkg::resp_okay);
    base = n_close;
    pins(8'h00, 2'h1);
    `CHECK("no close after reset", base, n_close)
    axi_read(lin_pkg::off_status, lin_pkg::resp_okay);
    `CHECK("pending after reset", 1'b0, rd[lin_pkg::st_close_pending])
    $display("test close done");
    print_verdict();
  end
endmodule
